// File: hdl/tmsd_consts.svh
// Constants for the touch matrix scan and detect block
`ifndef TMSD_CONSTS_SVH
`define TMSD_CONSTS_SVH

// ==========================================================
// Matrix geometry
`define TMSD_NUM_DRIVE     8
`define TMSD_NUM_GATE      4
`define TMSD_NUM_KEYS      32
`define TMSD_SAMPLE_W      10
`define TMSD_COUNT_CONFIRM 3'h4
`define TMSD_STAMP_W       14

// ==========================================================
// Pulse timing in ns and derived cycle counts
`define TMSD_CLK_PERIOD_NS 4
`define TMSD_GATE_LEAD_NS  8
`define TMSD_GATE_LAG_NS   8
`define TMSD_DRIVE_HIGH_NS 400
`define TMSD_PERIOD_NS     1000
`define TMSD_SETTLE_NS     2000
`define TMSD_GATE_LEAD_CYC ((`TMSD_GATE_LEAD_NS + `TMSD_CLK_PERIOD_NS - 1) / `TMSD_CLK_PERIOD_NS)
`define TMSD_GATE_LAG_CYC  ((`TMSD_GATE_LAG_NS + `TMSD_CLK_PERIOD_NS - 1) / `TMSD_CLK_PERIOD_NS)
`define TMSD_DRIVE_END_CYC (`TMSD_GATE_LEAD_CYC + `TMSD_DRIVE_HIGH_NS / `TMSD_CLK_PERIOD_NS)
`define TMSD_PERIOD_CYC    ((`TMSD_PERIOD_NS + `TMSD_CLK_PERIOD_NS - 1) / `TMSD_CLK_PERIOD_NS)
`define TMSD_SETTLE_CYC    ((`TMSD_SETTLE_NS + `TMSD_CLK_PERIOD_NS - 1) / `TMSD_CLK_PERIOD_NS)

// ==========================================================
// Max on-duration, counted in millisecond ticks
`define TMSD_TICK_NS       1000000
`define TMSD_TICK_CYC      (`TMSD_TICK_NS / `TMSD_CLK_PERIOD_NS)
`define TMSD_MAX_ON_S      10
`define TMSD_MAX_ON_TICKS  (`TMSD_MAX_ON_S * 1000)

// ==========================================================
// Drift slew: pass-count masks, raising is four times faster
`define TMSD_DRIFT_UP_MASK 4'h1
`define TMSD_DRIFT_DN_MASK 4'h7

`endif

// File: hdl/tmsd_pkg.sv
// Types for the touch matrix scan and detect block
`include "tmsd_consts.svh"
package tmsd_pkg;
	typedef enum logic [1:0] {
		TMSD_BURST,
		TMSD_SETTLE,
		TMSD_CONVERT
	} tmsd_state_t;

	typedef struct packed {
		tmsd_state_t                                          state;
		logic [4:0]                                           key;
		logic [9:0]                                           phase;
		logic [7:0]                                           pulses;
		logic [3:0]                                           pass;
		logic [17:0]                                          tick;
		logic [`TMSD_STAMP_W-1:0]                             now;
		logic [`TMSD_NUM_DRIVE-1:0]                           drive;
		logic [`TMSD_NUM_GATE-1:0]                            gate;
		logic                                                 adc_start;
		logic                                                 busy;
		logic [`TMSD_NUM_KEYS-1:0][`TMSD_SAMPLE_W-1:0]        ref_lvl;
		logic [`TMSD_NUM_KEYS-1:0][2:0]                       count;
		logic [`TMSD_NUM_KEYS-1:0]                            det;
		logic [`TMSD_NUM_KEYS-1:0]                            cal;
		logic [`TMSD_NUM_KEYS-1:0][`TMSD_STAMP_W-1:0]         start;
	} tmsd_regs_t;
endpackage

// File: hdl/tmsd_key_update.sv
// Per-key detection, drift and max on-duration update
`timescale 1ns/1ps
`default_nettype none
`include "tmsd_consts.svh"
module tmsd_key_update (
	input  wire logic [`TMSD_SAMPLE_W-1:0] sample_in,
	input  wire logic [7:0]                delta_in,
	input  wire logic [`TMSD_SAMPLE_W-1:0] ref_in,
	input  wire logic [2:0]                count_in,
	input  wire logic                      det_in,
	input  wire logic                      cal_in,
	input  wire logic [`TMSD_STAMP_W-1:0]  start_in,
	input  wire logic [`TMSD_STAMP_W-1:0]  now_in,
	input  wire logic                      up_en_in,
	input  wire logic                      dn_en_in,
	output logic      [`TMSD_SAMPLE_W-1:0] ref_out,
	output logic      [2:0]                count_out,
	output logic                           det_out,
	output logic      [`TMSD_STAMP_W-1:0]  start_out,
	output logic                           timeout_out
);
	logic [10:0]              sig_plus_delta;
	logic [10:0]              ref_wide;
	logic [10:0]              ref_plus_hyst;
	logic [`TMSD_STAMP_W-1:0] held;

	// ==========================================================
	// Threshold and hysteresis referred to the reference
	assign sig_plus_delta = {1'b0, sample_in} + {3'b0, delta_in};
	assign ref_wide       = {1'b0, ref_in};
	assign ref_plus_hyst  = ref_wide + {5'b0, delta_in[7:2]};
	assign held           = now_in - start_in;

	// Next state of one key
	always_comb begin
		ref_out     = ref_in;
		count_out   = count_in;
		det_out     = det_in;
		start_out   = start_in;
		timeout_out = 1'b0;
		if (cal_in) begin
			ref_out   = sample_in;
			count_out = 3'h0;
			det_out   = 1'b0;
		end else if (det_in) begin
			if (sig_plus_delta >= ref_plus_hyst) begin
				det_out   = 1'b0;
				count_out = 3'h0;
			end else if (held >= `TMSD_STAMP_W'(`TMSD_MAX_ON_TICKS)) begin
				timeout_out = 1'b1;
			end
		end else begin
			// Only a fall below threshold counts
			if (sig_plus_delta < ref_wide) begin
				count_out = count_in + 3'h1;
				if (count_out == `TMSD_COUNT_CONFIRM) begin
					det_out   = 1'b1;
					start_out = now_in;
				end
			end else begin
				count_out = 3'h0;
			end
			// Slow asymmetric drift, frozen while detected
			if (up_en_in && sample_in > ref_in) begin
				ref_out = ref_in + `TMSD_SAMPLE_W'(1);
			end else if (dn_en_in && sample_in < ref_in) begin
				ref_out = ref_in - `TMSD_SAMPLE_W'(1);
			end
		end
	end
endmodule
`default_nettype wire

// File: hdl/tmsd_top.sv
// Touch matrix scanner: burst sequencing and per-key touch processing
// Summary of operation
// - One of 8 drive lines pulses at a time, burst length equals key gain.
// - Drive lines stepped in order, each getting all its bursts first.
// - Only drive rising edges are gated into the sample switch.
// - Four active-high gate lines, only the key's one asserted during a burst.
// - Gate rises shortly before drive rises and falls shortly after.
// - Power-up calibrates every key one at a time from its first sample.
// - Reference follows signal slew-limited, only while no detection.
// - Reference rises faster than it falls.
// - Only signal falls detect; signal rises never detect.
// - Threshold sits a fixed offset below the moving reference.
// - Release after signal rises 25% of threshold-to-reference above threshold.
// - Detection lasting 10 seconds forces full recalibration.
// - After timeout recalibration the key detects normally again.
// - Integrator counts below-threshold samples to 4; any miss clears it.
// - Burst length is a per-key setting from the setup store.
// - After the burst the offset code drives lines while sampling.
// - Host command also starts a calibration cycle.
`timescale 1ns/1ps
`default_nettype none
`include "tmsd_consts.svh"
module tmsd_top #(
	parameter logic [17:0] TICK_CYCLES = 18'(`TMSD_TICK_CYC)
) (
	input  wire logic                       clock_in,
	input  wire logic                       reset_n_in,
	input  wire logic [7:0]                 burst_len_in,
	input  wire logic [7:0]                 thresh_delta_in,
	input  wire logic [7:0]                 offset_code_in,
	input  wire logic                       adc_valid_in,
	input  wire logic [`TMSD_SAMPLE_W-1:0]  adc_data_in,
	input  wire logic                       calibrate_in,
	output logic      [`TMSD_NUM_DRIVE-1:0] drive_lines_out,
	output logic      [`TMSD_NUM_GATE-1:0]  gate_lines_out,
	output logic                            adc_start_out,
	output logic      [4:0]                 key_sel_out,
	output logic      [`TMSD_NUM_KEYS-1:0]  touch_state_out,
	output logic                            calibrating_out
);
	tmsd_pkg::tmsd_regs_t     r_q;
	tmsd_pkg::tmsd_regs_t     r_d;
	tmsd_pkg::tmsd_regs_t     r_rst;
	logic [2:0]               drive_idx;
	logic [1:0]               gate_idx;
	logic [7:0]               burst_len;
	logic                     up_en;
	logic                     dn_en;
	logic [`TMSD_SAMPLE_W-1:0] ref_n;
	logic [2:0]               count_n;
	logic                     det_n;
	logic [`TMSD_STAMP_W-1:0] start_n;
	logic                     timeout;
	logic                     tick_wrap;
	logic                     gate_win;
	logic                     drive_win;
	logic                     pulse_end;
	logic                     burst_done;
	logic                     settle_end;
	logic                     last_key;
	logic                     take;

	// ==========================================================
	// Key numbering: drive line in high bits, gate line in low bits
	assign drive_idx = r_q.key[4:2];
	assign gate_idx  = r_q.key[1:0];
	assign burst_len = (burst_len_in == 8'h00) ? 8'h01 : burst_len_in;
	assign up_en     = (r_q.pass & `TMSD_DRIFT_UP_MASK) == 4'h0;
	assign dn_en     = (r_q.pass & `TMSD_DRIFT_DN_MASK) == 4'h0;

	// ==========================================================
	// Phase decode of the pulse and settle windows
	assign tick_wrap  = r_q.tick >= TICK_CYCLES - 18'h00001;
	assign gate_win   = r_q.phase < 10'(`TMSD_GATE_LEAD_CYC + `TMSD_GATE_LAG_CYC);
	assign drive_win  = (r_q.phase >= 10'(`TMSD_GATE_LEAD_CYC))
		&& (r_q.phase < 10'(`TMSD_DRIVE_END_CYC));
	assign pulse_end  = r_q.phase == 10'(`TMSD_PERIOD_CYC - 1);
	assign burst_done = (r_q.pulses + 8'h01) >= burst_len;
	assign settle_end = r_q.phase == 10'(`TMSD_SETTLE_CYC - 1);

	// Scan position and sample acceptance
	assign last_key   = r_q.key == 5'h1F;
	assign take       = (r_q.state == tmsd_pkg::TMSD_CONVERT) && adc_valid_in;

	// Reset image: every key awaits calibration
	always_comb begin
		r_rst       = '0;
		r_rst.state = tmsd_pkg::TMSD_BURST;
		r_rst.cal   = '1;
		r_rst.busy  = 1'b1;
	end

	// ==========================================================
	// Processing of the key whose sample is arriving
	tmsd_key_update u_key (
		.sample_in   (adc_data_in),
		.delta_in    (thresh_delta_in),
		.ref_in      (r_q.ref_lvl[r_q.key]),
		.count_in    (r_q.count[r_q.key]),
		.det_in      (r_q.det[r_q.key]),
		.cal_in      (r_q.cal[r_q.key]),
		.start_in    (r_q.start[r_q.key]),
		.now_in      (r_q.now),
		.up_en_in    (up_en),
		.dn_en_in    (dn_en),
		.ref_out     (ref_n),
		.count_out   (count_n),
		.det_out     (det_n),
		.start_out   (start_n),
		.timeout_out (timeout)
	);

	// ==========================================================
	// Sequencer and state update
	always_comb begin
		r_d           = r_q;
		r_d.adc_start = 1'b0;
		r_d.phase     = r_q.phase + 10'h001;
		// Millisecond time base for on-duration
		if (tick_wrap) begin
			r_d.tick = 18'h00000;
			r_d.now  = r_q.now + `TMSD_STAMP_W'(1);
		end else begin
			r_d.tick = r_q.tick + 18'h00001;
		end

		unique case (r_q.state)
			tmsd_pkg::TMSD_BURST: begin
				// Gate straddles drive rise; drive fall lands with gate off
				r_d.drive = '0;
				r_d.gate  = '0;
				if (gate_win) begin
					r_d.gate[gate_idx] = 1'b1;
				end
				if (drive_win) begin
					r_d.drive[drive_idx] = 1'b1;
				end
				// Pulse period over: count it, leave after the last
				if (pulse_end) begin
					r_d.phase  = 10'h000;
					r_d.pulses = r_q.pulses + 8'h01;
					if (burst_done) begin
						r_d.pulses = 8'h00;
						r_d.state  = tmsd_pkg::TMSD_SETTLE;
					end
				end
			end
			tmsd_pkg::TMSD_SETTLE: begin
				// Offset code on drive lines while the amplifier settles
				r_d.gate  = '0;
				r_d.drive = offset_code_in;
				if (settle_end) begin
					r_d.adc_start = 1'b1;
					r_d.state     = tmsd_pkg::TMSD_CONVERT;
				end
			end
			tmsd_pkg::TMSD_CONVERT: begin
				// Offset code holds until the converted sample arrives
				r_d.drive = offset_code_in;
				if (take) begin
					// Store the processed key, then step to the next
					r_d.ref_lvl[r_q.key] = ref_n;
					r_d.count[r_q.key]   = count_n;
					r_d.det[r_q.key]     = det_n;
					r_d.start[r_q.key]   = start_n;
					r_d.cal[r_q.key]     = 1'b0;
					r_d.phase            = 10'h000;
					r_d.drive            = '0;
					r_d.key              = r_q.key + 5'h01;
					r_d.state            = tmsd_pkg::TMSD_BURST;
					// Count full scans for drift pacing
					if (last_key) begin
						r_d.pass = r_q.pass + 4'h1;
					end
					// Timeout recalibrates all keys, which then resume
					if (timeout) begin
						r_d.cal = '1;
						r_d.det = '0;
					end
				end
			end
			default: begin
				// Unused state code: restart with a fresh burst
				r_d.state = tmsd_pkg::TMSD_BURST;
				r_d.phase = 10'h000;
			end
		endcase

		// Host command recalibration
		if (calibrate_in) begin
			r_d.cal = '1;
			r_d.det = '0;
		end
		// Calibration pending flag, registered for the output
		r_d.busy = |r_d.cal;
	end

	// Register update
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			r_q <= r_rst;
		end else begin
			r_q <= r_d;
		end
	end

	// ==========================================================
	// Outputs straight from the state register
	// Matrix pins
	assign drive_lines_out = r_q.drive;
	assign gate_lines_out  = r_q.gate;

	// Converter start and current key
	assign adc_start_out   = r_q.adc_start;
	assign key_sel_out     = r_q.key;

	// Host-visible touch and calibration state
	assign touch_state_out = r_q.det;
	assign calibrating_out = r_q.busy;
endmodule
`default_nettype wire

// File: test/tmsd_props.sv
// Port checker for the touch matrix scanner
`timescale 1ns/1ps
`default_nettype none
module tmsd_props #(
	parameter logic [17:0] TICK_CYCLES = 18'h4
) (
	input wire logic        clock_in,
	input wire logic        reset_n_in,
	input wire logic [7:0]  burst_len_in,
	input wire logic [7:0]  thresh_delta_in,
	input wire logic [7:0]  offset_code_in,
	input wire logic        adc_valid_in,
	input wire logic [9:0]  adc_data_in,
	input wire logic        calibrate_in,
	input wire logic [7:0]  drive_lines_out,
	input wire logic [3:0]  gate_lines_out,
	input wire logic        adc_start_out,
	input wire logic [4:0]  key_sel_out,
	input wire logic [31:0] touch_state_out,
	input wire logic        calibrating_out
);
	// ==========================================================
	// Gated drive rising edges counted per burst
	logic [7:0] drv_q;
	logic [7:0] rise_q;
	wire        rise = (|gate_lines_out) && (|drive_lines_out) && !(|drv_q);
	always_ff @(posedge clock_in) begin
		drv_q <= drive_lines_out;
		if (!reset_n_in || adc_start_out) rise_q <= 8'h0;
		else if (rise) rise_q <= rise_q + 8'h1;
	end
	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);
	a_gate_one_hot: assert property ($onehot0(gate_lines_out))
		else $error("gate lines not one-hot");
	a_gate_key_match: assert property (|gate_lines_out |-> gate_lines_out == (4'h1 << key_sel_out[1:0]))
		else $error("gate line does not match key");
	a_drive_key_match: assert property (rise |-> drive_lines_out == (8'h1 << key_sel_out[4:2]))
		else $error("drive line does not match key");
	a_gate_leads_drive: assert property (rise |-> $past(gate_lines_out, 2) == gate_lines_out)
		else $error("gate did not lead drive rise");
	a_gate_lags_drive: assert property (rise |-> ##2 (gate_lines_out == 4'h0 && |drive_lines_out))
		else $error("gate did not fall after drive rise");
	a_gate_then_rise: assert property (|gate_lines_out && $past(gate_lines_out) == 4'h0 |-> ##2 rise)
		else $error("drive did not rise after gate");
	a_burst_pulse_count: assert property (adc_start_out |-> rise_q == ((burst_len_in == 8'h0) ? 8'h1 : burst_len_in))
		else $error("burst pulse count wrong");
	a_settle_offset_code: assert property (adc_start_out |-> drive_lines_out == offset_code_in && gate_lines_out == 4'h0)
		else $error("offset code not on drive lines");
	a_start_single: assert property (adc_start_out |=> !adc_start_out [*3])
		else $error("conversion start not a single pulse");
	a_touch_has_cause: assert property (touch_state_out != $past(touch_state_out) |-> $past(adc_valid_in) || $past(calibrate_in))
		else $error("touch state changed without a sample");
	a_cal_clears_touch: assert property (calibrate_in |=> touch_state_out == 32'h0 && calibrating_out)
		else $error("calibrate did not clear touches");
endmodule
bind tmsd_top tmsd_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (.clock_in(clock_in),
	.reset_n_in(reset_n_in), .burst_len_in(burst_len_in), .thresh_delta_in(thresh_delta_in),
	.offset_code_in(offset_code_in), .adc_valid_in(adc_valid_in), .adc_data_in(adc_data_in),
	.calibrate_in(calibrate_in), .drive_lines_out(drive_lines_out),
	.gate_lines_out(gate_lines_out), .adc_start_out(adc_start_out), .key_sel_out(key_sel_out),
	.touch_state_out(touch_state_out), .calibrating_out(calibrating_out));
`default_nettype wire

// File: test/tmsd_matrix.sv
// Electrode matrix, sample switch and converter model
`timescale 1ns/1ps
`default_nettype none
module tmsd_matrix (
	input  wire logic       clock_in,
	input  wire logic       reset_n_in,
	input  wire logic [7:0] drive_lines_in,
	input  wire logic [3:0] gate_lines_in,
	input  wire logic       adc_start_in,
	input  wire logic [9:0] level_in,
	output var logic        adc_valid_out = 1'b0,
	output var logic  [9:0] adc_data_out = 10'h0
);
	int         wait_n = 0;
	logic       slow = 1'b0;
	logic [3:0] seen = 4'h0;
	// Charge only where gate and drive overlap, unsampled gates grounded
	always @(negedge clock_in) begin
		seen <= adc_valid_out ? 4'h0 : seen | (gate_lines_in & {4{|drive_lines_in}});
		adc_valid_out <= (wait_n == 1);
		// Released bus toggles, answer alternately prompt and slow
		if (wait_n == 1) adc_data_out <= (|seen) ? level_in : 10'h0;
		else adc_data_out <= ~adc_data_out;
		if (wait_n > 0) wait_n <= wait_n - 1;
		else if (adc_start_in && reset_n_in) begin
			wait_n <= slow ? 7 : 2;
			slow <= !slow;
		end
	end
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the touch matrix scanner
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clock_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic [7:0]  burst_len_in = 8'h0;
	logic [7:0]  thresh_delta_in = 8'h0;
	logic [7:0]  offset_code_in = 8'h0;
	logic        calibrate_in = 1'b0;
	logic [9:0]  level = 10'h0;
	logic        adc_valid_in;
	logic [9:0]  adc_data_in;
	logic [7:0]  drive_lines_out;
	logic [3:0]  gate_lines_out;
	logic        adc_start_out;
	logic [4:0]  key_sel_out;
	logic [31:0] touch_state_out;
	logic        calibrating_out;
	localparam int TICK = 2;
	int          bad_count = 0, tests_run = 0, cycles = 0, pass_n = 0, due = 0, rel = 0;
	int          ref_m[32], cnt[32], st[32], dl[32], jit[32];
	logic [31:0] det = '0, cal = '1, seed = 32'h24B71111;
	tmsd_top #(.TICK_CYCLES(18'(TICK))) i_dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
		.burst_len_in(burst_len_in), .thresh_delta_in(thresh_delta_in),
		.offset_code_in(offset_code_in), .adc_valid_in(adc_valid_in), .adc_data_in(adc_data_in),
		.calibrate_in(calibrate_in), .drive_lines_out(drive_lines_out),
		.gate_lines_out(gate_lines_out), .adc_start_out(adc_start_out),
		.key_sel_out(key_sel_out), .touch_state_out(touch_state_out),
		.calibrating_out(calibrating_out));
	tmsd_matrix i_mdl (.clock_in(clock_in), .reset_n_in(reset_n_in),
		.drive_lines_in(drive_lines_out), .gate_lines_in(gate_lines_out),
		.adc_start_in(adc_start_out), .level_in(level), .adc_valid_out(adc_valid_in),
		.adc_data_out(adc_data_in));
	// ==========================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Key level per scan: touches, hysteresis edges, water film
	function automatic int lvl(input int k);
		if (k == 9 && pass_n > 0) return 700;
		if (k == 7 && pass_n == 5) return ref_m[7] - dl[7] + dl[7] / 4;
		if (k == 8 && pass_n == 5) return ref_m[8] - dl[8] + dl[8] / 4 - 1;
		if ((k inside {7, 8} && pass_n inside {[1:4]}) || (k == 6 && pass_n inside {1, 2, 3, 5}))
			return 380;
		return 500 + jit[k];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected touch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected flag at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results();
		if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Reference model of one processed sample
	task automatic step(input int k, input int s, input int d);
		int t;
		t = (cycles - rel - 1) / TICK;
		if (cal[k]) begin
			ref_m[k] = s; cnt[k] = 0; det[k] = 0; cal[k] = 0;
		end else if (det[k]) begin
			if (s + d >= ref_m[k] + d / 4) det[k] = 0;
			else if (t - st[k] >= 10000) begin cal = '1; det = '0; end
		end else begin
			if (s + d < ref_m[k]) cnt[k]++;
			else cnt[k] = 0;
			if (cnt[k] == 4) begin det[k] = 1; cnt[k] = 0; st[k] = t; end
			if (s > ref_m[k] && pass_n % 2 == 0) ref_m[k]++;
			else if (s < ref_m[k] && pass_n % 8 == 0) ref_m[k]--;
		end
		if (k == 31) pass_n++;
		jit[k] = seed % 8;
		seed = lfsr(seed);
		due = 1;
	endtask
	// ==========================================================
	// Clock, cycle limit and model sampling
	initial forever #2 clock_in = !clock_in;
	always @(posedge clock_in) begin
		cycles++;
		if (reset_n_in && adc_valid_in) step(key_sel_out, adc_data_in, thresh_delta_in);
		if (reset_n_in && calibrate_in) begin cal = '1; det = '0; end
		if (cycles > 165000) begin bad_count++; results(); end
	end
	// Inputs change on the falling edge, results compared there
	always @(negedge clock_in) begin
		burst_len_in <= (key_sel_out == 5'h0) ? 8'h3 : {7'h0, key_sel_out[0]};
		thresh_delta_in <= 8'(dl[key_sel_out]);
		offset_code_in <= {3'h0, key_sel_out};
		level <= 10'(lvl(int'(key_sel_out)));
		if (due) begin
			due = 0;
			chk(touch_state_out, det);
			chk1(calibrating_out, |cal);
		end
	end
	// Main sequence
	initial begin
		foreach (dl[i]) begin
			dl[i] = 32 + seed % 32;
			seed = lfsr(seed);
		end
		repeat (12) @(posedge clock_in);
		@(negedge clock_in) reset_n_in = 1'b1;
		rel = cycles;
		chk1(calibrating_out, 1'b1);
		wait (pass_n == 6);
		@(negedge clock_in) calibrate_in = 1'b1;
		@(negedge clock_in) calibrate_in = 1'b0;
		chk(touch_state_out, 32'h0);
		chk1(calibrating_out, 1'b1);
		results();
	end
endmodule
`default_nettype wire
